// [src/fpcs_pkg.sv]
// Field layout, reset values and encodings of the float control and status register
package fpcs_pkg;
  localparam int unsigned CSR_W          = 32;
  localparam int unsigned CC_HI_MSB      = 31;
  localparam int unsigned CC_HI_LSB      = 25;
  localparam int unsigned FLUSH_ZERO_BIT = 24;
  localparam int unsigned CC_LO_BIT      = 23;
  localparam int unsigned FLUSH_OVR_BIT  = 22;
  localparam int unsigned FLUSH_NEAR_BIT = 21;
  localparam int unsigned FUSED_BIT      = 20;
  localparam int unsigned ABSNEG_BIT     = 19;
  localparam int unsigned NANENC_BIT     = 18;
  localparam int unsigned CAUSE_MSB      = 17;
  localparam int unsigned CAUSE_LSB      = 12;
  localparam int unsigned UNIMPL_BIT     = 17;
  localparam int unsigned ENABLE_MSB     = 11;
  localparam int unsigned ENABLE_LSB     = 7;
  localparam int unsigned FLAG_MSB       = 6;
  localparam int unsigned FLAG_LSB       = 2;
  localparam int unsigned RMODE_MSB      = 1;
  localparam int unsigned RMODE_LSB      = 0;
  localparam int unsigned NUM_CC         = 8;

  // Fixed indicators: unfused multiply-add, 2008 abs/neg, 2008 NaN encoding
  localparam logic FUSED_VAL  = 1'h0;
  localparam logic ABSNEG_VAL = 1'h1;
  localparam logic NANENC_VAL = 1'h1;

  // Writable bits; the three indicators are read-only
  localparam logic [31:0] WRITE_MASK = 32'hFFE3_FFFF;
  localparam logic [31:0] CSR_RESET  = 32'h000C_0000;

  // Cause bit order below the unimplemented bit: V Z O U I
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO    = 2'h1;
  localparam logic [1:0] RM_PLUS    = 2'h2;
  localparam logic [1:0] RM_MINUS   = 2'h3;

  typedef enum logic [3:0] {
    TINY_KEEP     = 4'h1,
    TINY_ZERO     = 4'h2,
    TINY_MIN_NORM = 4'h4,
    TINY_TRAP     = 4'h8
  } tiny_action_type;
endpackage

// [src/tiny_result_policy.sv]
// Decides what happens to a tiny result from the flush controls and rounding mode
`timescale 1ns/100ps
`default_nettype none
module tiny_result_policy
(
  input  wire logic                      i_flush_zero,
  input  wire logic                      i_flush_ovr,
  input  wire logic                      i_flush_near,
  input  wire logic [1:0]                i_rmode,
  input  wire logic                      i_sign,
  input  wire logic                      i_half_or_more,
  output fpcs_pkg::tiny_action_type      o_action
);
  always_comb
  begin
    if (i_flush_ovr)
      o_action = fpcs_pkg::TINY_KEEP;
    else if (i_flush_near && i_rmode == fpcs_pkg::RM_NEAREST)
      o_action = i_half_or_more ? fpcs_pkg::TINY_MIN_NORM : fpcs_pkg::TINY_ZERO;
    else if (i_flush_zero || i_flush_near)
    begin
      // Directed modes round away only toward their own infinity
      unique case (i_rmode)
        fpcs_pkg::RM_PLUS:  o_action = i_sign ? fpcs_pkg::TINY_ZERO : fpcs_pkg::TINY_MIN_NORM;
        fpcs_pkg::RM_MINUS: o_action = i_sign ? fpcs_pkg::TINY_MIN_NORM : fpcs_pkg::TINY_ZERO;
        default:            o_action = fpcs_pkg::TINY_ZERO;
      endcase
    end
    else
      o_action = fpcs_pkg::TINY_TRAP;
  end
endmodule
`default_nettype wire

// [src/nan_classifier.sv]
// Classifies an operand as quiet or signaling NaN under the 2008 encoding
`timescale 1ns/100ps
`default_nettype none
module nan_classifier
(
  input  wire logic i_exp_all_ones,
  input  wire logic i_frac_msb,
  input  wire logic i_frac_rest_nonzero,
  output logic      o_quiet,
  output logic      o_signaling
);
  // Leading fraction bit one means quiet, zero with a nonzero rest of fraction means signaling
  assign o_quiet     = i_exp_all_ones && i_frac_msb;
  assign o_signaling = i_exp_all_ones && !i_frac_msb && i_frac_rest_nonzero;
endmodule
`default_nettype wire

// [src/float_control_status.sv]
// Float control and status register with compare codes, flush policy and exception causes
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Bits 31 to 25 and bit 23 hold the compare condition codes written by each comparison.
// - With flush-to-zero set, denormal operands count as zero and, unless flush-override is set, tiny results go to zero or the smallest normal.
// - With flush-to-zero clear, a denormal operand raises the unimplemented-operation exception.
// - With flush-override set, a tiny result is kept internally, unforced and without exception.
// - With flush-override and flush-to-nearest both clear, tiny results follow the flush-to-zero setting.
// - With flush-override clear, flush-to-nearest in round-to-nearest picks the nearer of zero and smallest normal, else acts as flush-to-zero.
// - Bit 20 reads zero, so multiply-add rounds the product before adding.
// - Bit 19 reads one, so absolute value and negate pass quiet NaNs without trapping.
// - Bit 18 reads one, so a quiet NaN has leading fraction bit one and a signaling NaN zero.
// - Bits 17 to 12 record the causes of each arithmetic instruction, bit 17 being unimplemented operation.
module float_control_status
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_csr_write,
  input  wire logic [31:0] i_csr_wdata,
  input  wire logic        i_cmp_valid,
  input  wire logic [2:0]  i_cmp_cc_sel,
  input  wire logic        i_cmp_true,
  input  wire logic        i_op_valid,
  input  wire logic        i_op_src_denormal,
  input  wire logic        i_op_tiny,
  input  wire logic        i_op_sign,
  input  wire logic        i_op_half_or_more,
  input  wire logic [4:0]  i_op_cause,
  input  wire logic        i_absneg_valid,
  input  wire logic        i_nan_exp_all_ones,
  input  wire logic        i_nan_frac_msb,
  input  wire logic        i_nan_frac_rest_nonzero,
  output logic [31:0]      o_float_control_status,
  output logic [1:0]       o_rounding_mode_field,
  output logic             o_flush_operands,
  output logic [3:0]       o_tiny_action,
  output logic             o_fp_exception,
  output logic             o_absneg_trap,
  output logic             o_nan_quiet,
  output logic             o_nan_signaling
);
  logic [31:0]               csr_r;
  logic [31:0]               csr_nxt;
  logic [7:0]                cc_r;
  logic [7:0]                cc_nxt;
  logic [5:0]                cause_nxt;
  logic [4:0]                enabled_hit;
  logic                      trap_nxt;
  logic                      flush_zero;
  logic                      flush_ovr;
  logic                      flush_near;
  logic [1:0]                rmode;
  logic [4:0]                enables;
  fpcs_pkg::tiny_action_type tiny_act;
  logic                      quiet;
  logic                      signaling;

  // Packs the split condition-code field back into eight bits
  function automatic logic [7:0] cc_of(input logic [31:0] v);
    cc_of = {v[fpcs_pkg::CC_HI_MSB:fpcs_pkg::CC_HI_LSB], v[fpcs_pkg::CC_LO_BIT]};
  endfunction

  assign flush_zero = csr_r[fpcs_pkg::FLUSH_ZERO_BIT];
  assign flush_ovr  = csr_r[fpcs_pkg::FLUSH_OVR_BIT];
  assign flush_near = csr_r[fpcs_pkg::FLUSH_NEAR_BIT];
  assign rmode      = csr_r[fpcs_pkg::RMODE_MSB:fpcs_pkg::RMODE_LSB];
  assign enables    = csr_r[fpcs_pkg::ENABLE_MSB:fpcs_pkg::ENABLE_LSB];
  assign cc_r       = cc_of(csr_r);

  tiny_result_policy u_tiny
  (
    .i_flush_zero   (flush_zero),
    .i_flush_ovr    (flush_ovr),
    .i_flush_near   (flush_near),
    .i_rmode        (rmode),
    .i_sign         (i_op_sign),
    .i_half_or_more (i_op_half_or_more),
    .o_action       (tiny_act)
  );

  nan_classifier u_nan
  (
    .i_exp_all_ones      (i_nan_exp_all_ones),
    .i_frac_msb          (i_nan_frac_msb),
    .i_frac_rest_nonzero (i_nan_frac_rest_nonzero),
    .o_quiet             (quiet),
    .o_signaling         (signaling)
  );

  // Causes of the current instruction; denormal input with flush-to-zero clear or untreatable tiny result is unimplemented
  always_comb
  begin
    cause_nxt = {1'h0, i_op_cause};
    if (i_op_src_denormal && !flush_zero)
      cause_nxt[5] = 1'h1;
    if (i_op_tiny && tiny_act == fpcs_pkg::TINY_TRAP)
      cause_nxt[5] = 1'h1;
    enabled_hit = cause_nxt[4:0] & enables;
    // Unimplemented operation cannot be masked
    trap_nxt = cause_nxt[5] || (enabled_hit != 5'h00);
  end

  // Comparison result lands in its selected code bit
  always_comb
  begin
    cc_nxt = cc_r;
    if (i_cmp_valid)
      cc_nxt[i_cmp_cc_sel] = i_cmp_true;
  end

  // Next register value; hardware events win over a same-cycle software write
  always_comb
  begin
    csr_nxt = csr_r;
    if (i_csr_write)
      csr_nxt = (i_csr_wdata & fpcs_pkg::WRITE_MASK) | (csr_r & ~fpcs_pkg::WRITE_MASK);
    if (i_cmp_valid)
    begin
      csr_nxt[fpcs_pkg::CC_HI_MSB:fpcs_pkg::CC_HI_LSB] = cc_nxt[7:1];
      csr_nxt[fpcs_pkg::CC_LO_BIT]                     = cc_nxt[0];
    end
    if (i_op_valid)
    begin
      csr_nxt[fpcs_pkg::CAUSE_MSB:fpcs_pkg::CAUSE_LSB] = cause_nxt;
      // Sticky flags gather causes only from instructions that did not trap
      if (!trap_nxt)
        csr_nxt[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB] =
          csr_nxt[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB] | cause_nxt[4:0];
    end
    csr_nxt[fpcs_pkg::FUSED_BIT]  = fpcs_pkg::FUSED_VAL;
    csr_nxt[fpcs_pkg::ABSNEG_BIT] = fpcs_pkg::ABSNEG_VAL;
    csr_nxt[fpcs_pkg::NANENC_BIT] = fpcs_pkg::NANENC_VAL;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      csr_r <= fpcs_pkg::CSR_RESET;
    else
      csr_r <= csr_nxt;
  end

  // Read copy and mode outputs follow the register one cycle later
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_float_control_status <= fpcs_pkg::CSR_RESET;
      o_rounding_mode_field  <= 2'h0;
      o_flush_operands       <= 1'h0;
    end
    else
    begin
      o_float_control_status <= csr_r;
      o_rounding_mode_field  <= rmode;
      o_flush_operands       <= flush_zero;
    end
  end

  // Per-instruction answers, valid the cycle after the instruction is offered
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tiny_action  <= 4'h0;
      o_fp_exception <= 1'h0;
    end
    else
    begin
      o_tiny_action  <= (i_op_valid && i_op_tiny) ? tiny_act : 4'h0;
      o_fp_exception <= i_op_valid && trap_nxt;
    end
  end

  // Abs and negate never trap on a quiet NaN; a signaling NaN traps only without 2008 mode
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_absneg_trap   <= 1'h0;
      o_nan_quiet     <= 1'h0;
      o_nan_signaling <= 1'h0;
    end
    else
    begin
      o_absneg_trap   <= i_absneg_valid && signaling && !csr_r[fpcs_pkg::ABSNEG_BIT];
      o_nan_quiet     <= quiet;
      o_nan_signaling <= signaling;
    end
  end

  property p_cmp_updates_cc;
    @(posedge i_clock) disable iff (i_rst)
    i_cmp_valid |=> cc_r[$past(i_cmp_cc_sel)] == $past(i_cmp_true);
  endproperty
  a_cmp_updates_cc: assert property (p_cmp_updates_cc) else $error("compare code not recorded");

  property p_denormal_traps;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_src_denormal && !flush_zero) |=> o_fp_exception && csr_r[fpcs_pkg::UNIMPL_BIT];
  endproperty
  a_denormal_traps: assert property (p_denormal_traps) else $error("denormal input did not trap");

  property p_flush_no_unimpl;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && flush_zero && !i_op_tiny && !i_csr_write) |=> !csr_r[fpcs_pkg::UNIMPL_BIT];
  endproperty
  a_flush_no_unimpl: assert property (p_flush_no_unimpl) else $error("flushed operand raised unimplemented");

  property p_override_keeps;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && flush_ovr) |=> o_tiny_action == fpcs_pkg::TINY_KEEP;
  endproperty
  a_override_keeps: assert property (p_override_keeps) else $error("override did not keep result");

  property p_nearest_pick;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && !flush_ovr && flush_near && rmode == fpcs_pkg::RM_NEAREST)
      |=> o_tiny_action == ($past(i_op_half_or_more) ? fpcs_pkg::TINY_MIN_NORM : fpcs_pkg::TINY_ZERO);
  endproperty
  a_nearest_pick: assert property (p_nearest_pick) else $error("flush to nearest chose wrong value");

  property p_no_flush_traps;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && !flush_ovr && !flush_near && !flush_zero) |=> o_fp_exception;
  endproperty
  a_no_flush_traps: assert property (p_no_flush_traps) else $error("unflushed tiny result did not trap");

  property p_indicators_fixed;
    @(posedge i_clock) disable iff (i_rst)
    i_csr_write |=> csr_r[fpcs_pkg::FUSED_BIT:fpcs_pkg::NANENC_BIT] == 3'h3 ##1
      o_float_control_status[fpcs_pkg::FUSED_BIT:fpcs_pkg::NANENC_BIT] == 3'h3;
  endproperty
  a_indicators_fixed: assert property (p_indicators_fixed) else $error("indicator bits changed");

  property p_absneg_qnan;
    @(posedge i_clock) disable iff (i_rst)
    (i_absneg_valid && quiet) |=> !o_absneg_trap && o_nan_quiet;
  endproperty
  a_absneg_qnan: assert property (p_absneg_qnan) else $error("quiet NaN trapped on abs or neg");

  property p_nan_encoding;
    @(posedge i_clock) disable iff (i_rst)
    (i_nan_exp_all_ones && !i_nan_frac_msb && i_nan_frac_rest_nonzero) |=> o_nan_signaling && !o_nan_quiet;
  endproperty
  a_nan_encoding: assert property (p_nan_encoding) else $error("signaling NaN misclassified");

  property p_cause_recorded;
    @(posedge i_clock) disable iff (i_rst)
    i_op_valid |=> csr_r[fpcs_pkg::CAUSE_MSB - 1:fpcs_pkg::CAUSE_LSB] == $past(i_op_cause) ##1
      o_float_control_status[fpcs_pkg::CAUSE_MSB - 1:fpcs_pkg::CAUSE_LSB] == $past(i_op_cause, 2);
  endproperty
  a_cause_recorded: assert property (p_cause_recorded) else $error("cause field not recorded");

  property p_flags_sticky;
    @(posedge i_clock) disable iff (i_rst)
    !i_csr_write |=> (csr_r[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB] & $past(csr_r[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB]))
      == $past(csr_r[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB]);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("sticky flag lost");

  property p_enabled_cause_traps;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && ((i_op_cause & enables) != 5'h00)) |=> o_fp_exception ##1 !o_fp_exception || $past(i_op_valid);
  endproperty
  a_enabled_cause_traps: assert property (p_enabled_cause_traps) else $error("enabled cause did not trap");

  property p_tiny_trap_cause;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && !flush_ovr && !flush_near && !flush_zero) |=> csr_r[fpcs_pkg::UNIMPL_BIT];
  endproperty
  a_tiny_trap_cause: assert property (p_tiny_trap_cause) else $error("tiny result not unimplemented");

  property p_flush_zero_chop;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && !flush_ovr && !flush_near && flush_zero && rmode == fpcs_pkg::RM_ZERO)
      |=> o_tiny_action == fpcs_pkg::TINY_ZERO;
  endproperty
  a_flush_zero_chop: assert property (p_flush_zero_chop) else $error("flushed tiny result not zero");

  property p_near_directed;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && i_op_tiny && !flush_ovr && flush_near && rmode != fpcs_pkg::RM_NEAREST)
      |=> o_tiny_action inside {fpcs_pkg::TINY_ZERO, fpcs_pkg::TINY_MIN_NORM};
  endproperty
  a_near_directed: assert property (p_near_directed) else $error("flush to nearest not flushing");

  property p_flags_gather;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && !i_csr_write) |=> o_fp_exception
      || ((csr_r[fpcs_pkg::FLAG_MSB:fpcs_pkg::FLAG_LSB] & $past(i_op_cause)) == $past(i_op_cause));
  endproperty
  a_flags_gather: assert property (p_flags_gather) else $error("sticky flag not gathered");

  property p_modes_follow;
    @(posedge i_clock) disable iff (i_rst)
    1'h1 |=> o_rounding_mode_field == $past(rmode) && o_flush_operands == $past(flush_zero);
  endproperty
  a_modes_follow: assert property (p_modes_follow) else $error("mode outputs lag register");

  property p_quiet_completion;
    @(posedge i_clock) disable iff (i_rst)
    (i_op_valid && !i_op_src_denormal && !i_op_tiny && ((i_op_cause & enables) == 5'h00)) |=> !o_fp_exception;
  endproperty
  a_quiet_completion: assert property (p_quiet_completion) else $error("masked cause raised exception");
endmodule
`default_nettype wire

// [dv/fp_core_model.sv]
// Core-side model issuing register writes, compares, arithmetic results and NaN operands
`timescale 1ns/100ps
`default_nettype none
module fp_core_model
(
  input  wire logic   i_clock,
  output logic        o_csr_write,
  output logic [31:0] o_csr_wdata,
  output logic        o_cmp_valid,
  output logic [2:0]  o_cmp_cc_sel,
  output logic        o_cmp_true,
  output logic        o_op_valid,
  output logic [3:0]  o_op_flags,
  output logic [4:0]  o_op_cause,
  output logic        o_absneg_valid,
  output logic [2:0]  o_nan_fields
);
  initial
  begin
    {o_csr_write, o_cmp_valid, o_cmp_true, o_op_valid, o_absneg_valid} = 5'h00;
    {o_csr_wdata, o_cmp_cc_sel, o_op_flags, o_op_cause, o_nan_fields} = 47'h0;
  end

  // Released write data and cause lines change so a stale value never looks like a live one
  task automatic go(input logic w, input logic c, input logic o);
    @(posedge i_clock);
    o_csr_write <= w;
    o_cmp_valid <= c;
    o_op_valid  <= o;
    if (!w)
      o_csr_wdata <= ~o_csr_wdata;
    if (!o)
      o_op_cause <= ~o_op_cause;
  endtask

  task automatic idle();
    go(1'h0, 1'h0, 1'h0);
    o_absneg_valid <= 1'h0;
  endtask

  task automatic csr(input logic [31:0] d);
    go(1'h1, 1'h0, 1'h0);
    o_csr_wdata <= d;
  endtask

  task automatic cmp(input logic [2:0] s, input logic t);
    go(1'h0, 1'h1, 1'h0);
    o_cmp_cc_sel <= s;
    o_cmp_true   <= t;
  endtask

  task automatic op(input logic [3:0] f, input logic [4:0] c);
    go(1'h0, 1'h0, 1'h1);
    o_op_flags <= f;
    o_op_cause <= c;
  endtask

  task automatic nan(input logic [2:0] v, input logic a);
    go(1'h0, 1'h0, 1'h0);
    o_nan_fields   <= v;
    o_absneg_valid <= a;
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the float control and status register
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct { int due; string name; logic [31:0] exp; } note_type;
  logic        i_clock;
  logic        i_rst;
  logic        csr_write, cmp_valid, cmp_true, op_valid, absneg_valid, t, exp_exc;
  logic        flush_ops, fp_exc, absneg_trap, nan_quiet, nan_sig;
  logic [31:0] csr_wdata, status, exp_csr, exp_tiny, seen, d;
  logic [4:0]  op_cause, c;
  logic [3:0]  op_flags, tiny_action, f;
  logic [2:0]  cmp_sel, nan_fields;
  logic [1:0]  rmode;
  int          seed, cnt, m;
  int          failures = 0;
  int          check_count = 0;
  note_type    notes[$];
  note_type    n;

  fp_core_model fp_core_model_i (.i_clock(i_clock), .o_csr_write(csr_write), .o_csr_wdata(csr_wdata),
    .o_cmp_valid(cmp_valid), .o_cmp_cc_sel(cmp_sel), .o_cmp_true(cmp_true), .o_op_valid(op_valid),
    .o_op_flags(op_flags), .o_op_cause(op_cause), .o_absneg_valid(absneg_valid), .o_nan_fields(nan_fields));

  float_control_status float_control_status_i (.i_clock(i_clock), .i_rst(i_rst), .i_csr_write(csr_write),
    .i_csr_wdata(csr_wdata), .i_cmp_valid(cmp_valid), .i_cmp_cc_sel(cmp_sel), .i_cmp_true(cmp_true),
    .i_op_valid(op_valid), .i_op_src_denormal(op_flags[3]), .i_op_tiny(op_flags[2]), .i_op_sign(op_flags[1]),
    .i_op_half_or_more(op_flags[0]), .i_op_cause(op_cause), .i_absneg_valid(absneg_valid),
    .i_nan_exp_all_ones(nan_fields[2]), .i_nan_frac_msb(nan_fields[1]), .i_nan_frac_rest_nonzero(nan_fields[0]),
    .o_float_control_status(status), .o_rounding_mode_field(rmode), .o_flush_operands(flush_ops),
    .o_tiny_action(tiny_action), .o_fp_exception(fp_exc), .o_absneg_trap(absneg_trap), .o_nan_quiet(nan_quiet),
    .o_nan_signaling(nan_sig));

  initial
  begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end

  function automatic logic [31:0] pick(input string s);
    case (s)
      "status": return status;
      "rmode":  return {30'h0, rmode};
      "flush":  return {31'h0, flush_ops};
      "tiny":   return {28'h0, tiny_action};
      "exc":    return {31'h0, fp_exc};
      "trap":   return {31'h0, absneg_trap};
      "quiet":  return {31'h0, nan_quiet};
      default:  return {31'h0, nan_sig};
    endcase
  endfunction

  // Outputs settle by the falling edge; a note left past its cycle is a miss
  initial
  begin
    cnt = 0;
    forever
    begin
      @(negedge i_clock);
      cnt = cnt + 1;
      while (notes.size() > 0 && notes[0].due <= cnt)
      begin
        n = notes.pop_front();
        seen = pick(n.name);
        check_count++;
        if (n.due != cnt || seen !== n.exp)
        begin
          failures++;
          $display("BAD %s expected %h seen %h", n.name, n.exp, seen);
        end
      end
    end
  end

  task automatic note(input int due, input string s, input logic [31:0] e);
    notes.push_back('{due, s, e});
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_rst <= 1'h1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'h0;
    exp_csr = fpcs_pkg::CSR_RESET;
    note(cnt + 1, "status", exp_csr);
    note(cnt + 1, "exc", 32'h0);
    note(cnt + 1, "tiny", 32'h0);
    note(cnt + 1, "rmode", 32'h0);
    note(cnt + 1, "flush", 32'h0);
    note(cnt + 1, "trap", 32'h0);
  endtask

  task automatic wr(input logic [31:0] v);
    exp_csr = v;
    exp_csr[20:18] = 3'h3;
  endtask

  task automatic arith();
    logic fs, fo, fn, un;
    logic [1:0] rm;
    {fs, fo, fn, rm} = {exp_csr[24], exp_csr[22:21], exp_csr[1:0]};
    un = (f[3] && !fs) || (f[2] && !fs && !fo && !fn);
    exp_exc = un || ((c & exp_csr[11:7]) != 5'h00);
    exp_csr[17:12] = {un, c};
    if (!exp_exc)
      exp_csr[6:2] = exp_csr[6:2] | c;
    if (!f[2])
      exp_tiny = 32'h0;
    else if (fo)
      exp_tiny = 32'h1;
    else if (fn && rm == 2'h0)
      exp_tiny = f[0] ? 32'h4 : 32'h2;
    else if (fs || fn)
      exp_tiny = (rm == 2'h2) ? (f[1] ? 32'h2 : 32'h4) : (rm == 2'h3) ? (f[1] ? 32'h4 : 32'h2) : 32'h2;
    else
      exp_tiny = 32'h8;
  endtask

  initial
  begin
    seed = 32'hBC51;
    i_rst = 1'h1;
    do_reset();
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0) ? 32'hFFFF_FFFF : 32'h0;
      fp_core_model_i.csr(d);
      wr(d);
      note(cnt + 3, "status", exp_csr);
    end
    for (int i = 0; i < 16; i++)
    begin
      t = (i < 8) ? 1'h1 : 1'($random(seed));
      fp_core_model_i.cmp(3'(i), t);
      if (i % 8 == 0)
        exp_csr[23] = t;
      else
        exp_csr[24 + i % 8] = t;
      note(cnt + 3, "status", exp_csr);
    end
    repeat (96)
    begin
      d = $random(seed);
      f = 4'($random(seed));
      c = 5'($random(seed));
      fp_core_model_i.csr(d);
      wr(d);
      note(cnt + 3, "status", exp_csr);
      fp_core_model_i.op(f, c);
      m = cnt;
      arith();
      note(m + 2, "exc", 32'(exp_exc));
      note(m + 2, "tiny", exp_tiny);
      fp_core_model_i.idle();
      note(m + 3, "status", exp_csr);
      note(m + 3, "exc", 32'h0);
      note(m + 3, "tiny", 32'h0);
      note(m + 3, "rmode", {30'h0, d[1:0]});
      note(m + 3, "flush", {31'h0, d[24]});
    end
    for (int i = 0; i < 8; i++)
    begin
      fp_core_model_i.nan(3'(i), i[0]);
      note(cnt + 2, "quiet", {31'h0, i[2] & i[1]});
      note(cnt + 2, "signal", {31'h0, i[2] & !i[1] & i[0]});
      note(cnt + 2, "trap", 32'h0);
    end
    repeat (4) fp_core_model_i.idle();
    do_reset();
    repeat (4) fp_core_model_i.idle();
    stop_test();
  end

  initial
  begin
    #(50 * 2000);
    failures++;
    stop_test();
  end

  task automatic stop_test();
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
endmodule
`default_nettype wire
